// ===== rtl/gfx_cap_pkg.sv
// Constants and carrier types for the graphics port capability registers
package gfx_cap_pkg;

  // Configuration offsets (byte addresses)
  localparam logic [7:0] CAP_ID_OFFSET = 8'hA0;
  localparam logic [7:0] PORT_STATUS_OFFSET = 8'hA4;
  localparam logic [7:0] PORT_COMMAND_OFFSET = 8'hA8;

  // Reset values
  localparam logic [31:0] CAP_ID_RESET = 32'h0010_0002;
  localparam logic [31:0] PORT_STATUS_RESET = 32'h1F00_0203;
  localparam logic [31:0] PORT_COMMAND_RESET = 32'h0000_0000;

  // Capability identifier fields
  localparam int CAP_MAJOR_LSB = 20;
  localparam int CAP_MINOR_LSB = 16;
  localparam int CAP_NEXT_LSB = 8;
  localparam int CAP_CODE_LSB = 0;
  localparam logic [3:0] CAP_MAJOR_REV = 4'h1;
  localparam logic [3:0] CAP_MINOR_REV = 4'h0;
  localparam logic [7:0] CAP_NEXT_PTR = 8'h00;
  localparam logic [7:0] CAP_CODE = 8'h02;

  // Status fields
  localparam int STAT_DEPTH_LSB = 24;
  localparam int STAT_SIDEBAND_BIT = 9;
  localparam int STAT_RATE_LSB = 0;
  localparam logic [7:0] STAT_DEPTH_RESET = 8'h1F;
  localparam logic [1:0] STAT_RATES = 2'h3;

  // Command fields steering the port
  localparam int CMD_SIDEBAND_EN_BIT = 9;
  localparam int CMD_PORT_EN_BIT = 8;
  localparam int CMD_RATE_LSB = 0;

  // Queue depth selections and their depth-minus-one codes
  localparam logic [2:0] DEPTH_SEL_32 = 3'h0;
  localparam logic [2:0] DEPTH_SEL_16 = 3'h1;
  localparam logic [2:0] DEPTH_SEL_8 = 3'h2;
  localparam logic [2:0] DEPTH_SEL_4 = 3'h3;
  localparam logic [2:0] DEPTH_SEL_2 = 3'h4;
  localparam logic [2:0] DEPTH_SEL_1 = 3'h5;
  localparam logic [5:0] DEPTH_CODE_32 = 6'h1F;
  localparam logic [5:0] DEPTH_CODE_16 = 6'h0F;
  localparam logic [5:0] DEPTH_CODE_8 = 6'h07;
  localparam logic [5:0] DEPTH_CODE_4 = 6'h03;
  localparam logic [5:0] DEPTH_CODE_2 = 6'h01;
  localparam logic [5:0] DEPTH_CODE_1 = 6'h00;

  // One configuration access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  // Read answer
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } cfg_rsp_t;

endpackage

// ===== rtl/gfx_queue_depth.sv
// Registered mapping of queue depth selection to reported depth code
`timescale 1ns/1ps
`default_nettype none
module gfx_queue_depth
  import gfx_cap_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_depth_sel,
  output logic [7:0] o_depth
);

  logic [7:0] depth_ff;
  logic [7:0] nxt_depth;

  // Only six discrete depths exist; other codes fall back to 32
  always_comb
  begin
    nxt_depth = 8'h00;
    case (i_depth_sel)
      DEPTH_SEL_32: nxt_depth[5:0] = DEPTH_CODE_32;
      DEPTH_SEL_16: nxt_depth[5:0] = DEPTH_CODE_16;
      DEPTH_SEL_8: nxt_depth[5:0] = DEPTH_CODE_8;
      DEPTH_SEL_4: nxt_depth[5:0] = DEPTH_CODE_4;
      DEPTH_SEL_2: nxt_depth[5:0] = DEPTH_CODE_2;
      DEPTH_SEL_1: nxt_depth[5:0] = DEPTH_CODE_1;
      default: nxt_depth[5:0] = DEPTH_CODE_32;
    endcase
  end

  // Depth register, upper two bits stay zero
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      depth_ff <= STAT_DEPTH_RESET;
    else
      depth_ff <= nxt_depth;
  end

  assign o_depth = depth_ff;

endmodule
`default_nettype wire

// ===== rtl/gfx_cap_regs.sv
// Graphics port capability, status and command registers in config space
// Functional notes
// - Read-only capability identifier at A0, 00100002
// - Identifier bits 23:20 read major revision 1
// - Identifier bits 19:16 read minor revision 0
// - Identifier bits 15:8 zero, list ends here
// - Identifier bits 7:0 hold capability code
// - Status register at A4, resets 1F000203
// - Status 31:24 mirror programmed queue depth
// - Depth limited to 32,16,8,4,2,1 requests
// - Status bit 9 reads one, sideband
// - Status bits 1:0 read 11, both rates
// - Read/write command register at A8, resets zero
`timescale 1ns/1ps
`default_nettype none
module gfx_cap_regs
  import gfx_cap_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire cfg_req_t i_cfg_req,
  input wire logic [2:0] i_depth_sel,
  output cfg_rsp_t o_cfg_rsp,
  output logic o_sideband_en,
  output logic o_port_en,
  output logic [1:0] o_rate_sel
);

  // Word decode of a configuration byte address
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offs);
    hit = (addr[7:2] == offs[7:2]);
  endfunction

  // Byte-enable merge of write data into an old value
  function automatic logic [31:0] merge(input logic [31:0] old_val,
                                        input logic [31:0] new_val,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[i*8 +: 8] = new_val[i*8 +: 8];
    end
    merge = res;
  endfunction

  logic [7:0] depth;
  logic [31:0] cap_id_val;
  logic [31:0] status_val;
  logic [31:0] command_ff;
  logic [31:0] nxt_command;
  logic rsp_ack_ff;
  logic nxt_rsp_ack;
  logic [31:0] rsp_data_ff;
  logic [31:0] nxt_rsp_data;
  logic sideband_en_ff;
  logic port_en_ff;
  logic [1:0] rate_sel_ff;
  logic nxt_sideband_en;
  logic nxt_port_en;
  logic [1:0] nxt_rate_sel;

  // Queue depth mirror of the control selection
  gfx_queue_depth u_depth (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_depth_sel(i_depth_sel),
    .o_depth(depth)
  );

  // Hardwired identifier, no storage so writes cannot reach it
  always_comb
  begin
    cap_id_val = 32'h0000_0000;
    cap_id_val[CAP_MAJOR_LSB +: 4] = CAP_MAJOR_REV;
    cap_id_val[CAP_MINOR_LSB +: 4] = CAP_MINOR_REV;
    cap_id_val[CAP_NEXT_LSB +: 8] = CAP_NEXT_PTR;
    cap_id_val[CAP_CODE_LSB +: 8] = CAP_CODE;
  end

  // Status word: depth mirror plus hardwired capabilities
  always_comb
  begin
    status_val = 32'h0000_0000;
    status_val[STAT_DEPTH_LSB +: 8] = depth;
    status_val[STAT_SIDEBAND_BIT] = 1'b1;
    status_val[STAT_RATE_LSB +: 2] = STAT_RATES;
  end

  // Command register next value and its decoded controls
  always_comb
  begin
    nxt_command = command_ff;
    if (i_cfg_req.wr && hit(i_cfg_req.addr, PORT_COMMAND_OFFSET))
      nxt_command = merge(command_ff, i_cfg_req.wdata, i_cfg_req.be);
    nxt_sideband_en = nxt_command[CMD_SIDEBAND_EN_BIT];
    nxt_port_en = nxt_command[CMD_PORT_EN_BIT];
    nxt_rate_sel = nxt_command[CMD_RATE_LSB +: 2];
  end

  // Command register and control outputs
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      command_ff <= PORT_COMMAND_RESET;
      sideband_en_ff <= 1'b0;
      port_en_ff <= 1'b0;
      rate_sel_ff <= 2'h0;
    end
    else
    begin
      command_ff <= nxt_command;
      sideband_en_ff <= nxt_sideband_en;
      port_en_ff <= nxt_port_en;
      rate_sel_ff <= nxt_rate_sel;
    end
  end

  // Read mux, unmapped addresses answer zero
  always_comb
  begin
    nxt_rsp_ack = i_cfg_req.rd || i_cfg_req.wr;
    nxt_rsp_data = 32'h0000_0000;
    if (i_cfg_req.rd)
    begin
      if (hit(i_cfg_req.addr, CAP_ID_OFFSET))
        nxt_rsp_data = cap_id_val;
      else if (hit(i_cfg_req.addr, PORT_STATUS_OFFSET))
        nxt_rsp_data = status_val;
      else if (hit(i_cfg_req.addr, PORT_COMMAND_OFFSET))
        nxt_rsp_data = command_ff;
    end
  end

  // Answer register, one cycle after the request
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rsp_ack_ff <= 1'b0;
      rsp_data_ff <= 32'h0000_0000;
    end
    else
    begin
      rsp_ack_ff <= nxt_rsp_ack;
      rsp_data_ff <= nxt_rsp_data;
    end
  end

  assign o_cfg_rsp = {rsp_ack_ff, rsp_data_ff}; // Both fields straight from flip-flops
  assign o_sideband_en = sideband_en_ff;
  assign o_port_en = port_en_ff;
  assign o_rate_sel = rate_sel_ff;

  // Checks on the register behaviour
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // Identifier reads return the fixed word
  a_cap_id_read: assert property (
    i_cfg_req.rd && hit(i_cfg_req.addr, CAP_ID_OFFSET) |=> o_cfg_rsp.rdata == CAP_ID_RESET)
    else $error("identifier read wrong");

  // Major revision field
  a_major_rev_field: assert property (
    i_cfg_req.rd && hit(i_cfg_req.addr, CAP_ID_OFFSET) |=> o_cfg_rsp.rdata[23:20] == 4'h1)
    else $error("major revision wrong");

  // Minor revision field
  a_minor_rev_field: assert property (
    i_cfg_req.rd && hit(i_cfg_req.addr, CAP_ID_OFFSET) |=> o_cfg_rsp.rdata[19:16] == 4'h0)
    else $error("minor revision wrong");

  // Next pointer ends the list
  a_next_ptr_zero: assert property (
    i_cfg_req.rd && hit(i_cfg_req.addr, CAP_ID_OFFSET) |=> o_cfg_rsp.rdata[15:8] == 8'h00)
    else $error("next pointer not zero");

  // Capability code byte
  a_cap_code_byte: assert property (
    i_cfg_req.rd && hit(i_cfg_req.addr, CAP_ID_OFFSET) |=> o_cfg_rsp.rdata[7:0] == 8'h02)
    else $error("capability code wrong");

  // Status depth follows a steady selection after two cycles
  a_status_depth: assert property (
    i_depth_sel == 3'h1 ##1 (i_depth_sel == 3'h1 && i_cfg_req.rd &&
      hit(i_cfg_req.addr, PORT_STATUS_OFFSET)) |=> o_cfg_rsp.rdata[31:24] == 8'h0F)
    else $error("status depth wrong");

  // Status constant bits
  a_status_consts: assert property (
    i_cfg_req.rd && hit(i_cfg_req.addr, PORT_STATUS_OFFSET) |=>
      o_cfg_rsp.rdata[23:0] == 24'h00_0203)
    else $error("status constant bits wrong");

  // Command write then read returns the written word
  a_command_rw: assert property (
    i_cfg_req.wr && !i_cfg_req.rd && hit(i_cfg_req.addr, PORT_COMMAND_OFFSET) &&
      i_cfg_req.be == 4'hF ##1 i_cfg_req.rd && !i_cfg_req.wr &&
      hit(i_cfg_req.addr, PORT_COMMAND_OFFSET)
    |=> o_cfg_rsp.rdata == $past(i_cfg_req.wdata, 2))
    else $error("command readback wrong");

  // Writes to the read-only identifier leave it unchanged
  a_ro_ignore_write: assert property (
    i_cfg_req.wr && hit(i_cfg_req.addr, CAP_ID_OFFSET) ##1
      i_cfg_req.rd && hit(i_cfg_req.addr, CAP_ID_OFFSET) |=> o_cfg_rsp.rdata == CAP_ID_RESET)
    else $error("identifier changed by write");

  // Controls follow the written command bytes one cycle later
  a_port_en_follow: assert property (
    i_cfg_req.wr && hit(i_cfg_req.addr, PORT_COMMAND_OFFSET) && i_cfg_req.be[1] |=>
      o_port_en == $past(i_cfg_req.wdata[CMD_PORT_EN_BIT]))
    else $error("port enable mismatch");

  a_sideband_en_follow: assert property (
    i_cfg_req.wr && hit(i_cfg_req.addr, PORT_COMMAND_OFFSET) && i_cfg_req.be[1] |=>
      o_sideband_en == $past(i_cfg_req.wdata[CMD_SIDEBAND_EN_BIT]))
    else $error("sideband enable mismatch");

  a_rate_sel_follow: assert property (
    i_cfg_req.wr && hit(i_cfg_req.addr, PORT_COMMAND_OFFSET) && i_cfg_req.be[0] |=>
      o_rate_sel == $past(i_cfg_req.wdata[CMD_RATE_LSB +: 2]))
    else $error("rate select mismatch");

  // Every access answered exactly one cycle later, and nothing else
  a_ack_one_cycle: assert property (
    (i_cfg_req.rd || i_cfg_req.wr) |=> o_cfg_rsp.ack)
    else $error("access not answered");

  a_no_spurious_ack: assert property (
    !(i_cfg_req.rd || i_cfg_req.wr) |=> !o_cfg_rsp.ack)
    else $error("answer without access");

  // Write-only answers carry no data
  a_write_data_zero: assert property (
    i_cfg_req.wr && !i_cfg_req.rd |=> o_cfg_rsp.rdata == 32'h0000_0000)
    else $error("write answer carries data");

  // Unmapped words read zero
  a_unmapped_zero: assert property (
    i_cfg_req.rd && !hit(i_cfg_req.addr, CAP_ID_OFFSET) &&
      !hit(i_cfg_req.addr, PORT_STATUS_OFFSET) && !hit(i_cfg_req.addr, PORT_COMMAND_OFFSET)
      |=> o_cfg_rsp.rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Depth field: top bits zero, only the six legal codes
  a_depth_upper_zero: assert property (
    i_cfg_req.rd && hit(i_cfg_req.addr, PORT_STATUS_OFFSET) |=>
      o_cfg_rsp.rdata[31:30] == 2'h0)
    else $error("depth upper bits set");

  a_depth_legal: assert property (
    i_cfg_req.rd && hit(i_cfg_req.addr, PORT_STATUS_OFFSET) |=>
      o_cfg_rsp.rdata[29:24] inside {6'h1F, 6'h0F, 6'h07, 6'h03, 6'h01, 6'h00})
    else $error("depth code not legal");

  // Command word moves only on a command write
  a_command_hold: assert property (
    !(i_cfg_req.wr && hit(i_cfg_req.addr, PORT_COMMAND_OFFSET)) |=> $stable(command_ff))
    else $error("command changed without write");

  // Reset clears answer and controls, checked while reset is high
  a_reset_clears: assert property (disable iff (1'b0)
    i_rst |=> !o_cfg_rsp.ack && o_cfg_rsp.rdata == 32'h0000_0000 && !o_port_en &&
      !o_sideband_en && o_rate_sel == 2'h0)
    else $error("reset did not clear outputs");

  // Selections 0 and 2 to 5 report their depth-minus-one code, and code 7 falls back to 32, two cycles on
  a_depth_sel_32: assert property (
    i_depth_sel == 3'h0 ##1 (i_depth_sel == 3'h0 && i_cfg_req.rd &&
      hit(i_cfg_req.addr, PORT_STATUS_OFFSET)) |=> o_cfg_rsp.rdata[31:24] == 8'h1F)
    else $error("depth for 32 wrong");

  a_depth_sel_8: assert property (
    i_depth_sel == 3'h2 ##1 (i_depth_sel == 3'h2 && i_cfg_req.rd &&
      hit(i_cfg_req.addr, PORT_STATUS_OFFSET)) |=> o_cfg_rsp.rdata[31:24] == 8'h07)
    else $error("depth for 8 wrong");

  a_depth_sel_4: assert property (
    i_depth_sel == 3'h3 ##1 (i_depth_sel == 3'h3 && i_cfg_req.rd &&
      hit(i_cfg_req.addr, PORT_STATUS_OFFSET)) |=> o_cfg_rsp.rdata[31:24] == 8'h03)
    else $error("depth for 4 wrong");

  a_depth_sel_2: assert property (
    i_depth_sel == 3'h4 ##1 (i_depth_sel == 3'h4 && i_cfg_req.rd &&
      hit(i_cfg_req.addr, PORT_STATUS_OFFSET)) |=> o_cfg_rsp.rdata[31:24] == 8'h01)
    else $error("depth for 2 wrong");

  a_depth_sel_1: assert property (
    i_depth_sel == 3'h5 ##1 (i_depth_sel == 3'h5 && i_cfg_req.rd &&
      hit(i_cfg_req.addr, PORT_STATUS_OFFSET)) |=> o_cfg_rsp.rdata[31:24] == 8'h00)
    else $error("depth for 1 wrong");

  a_depth_sel_fallback: assert property (
    i_depth_sel == 3'h7 ##1 (i_depth_sel == 3'h7 && i_cfg_req.rd &&
      hit(i_cfg_req.addr, PORT_STATUS_OFFSET)) |=> o_cfg_rsp.rdata[31:24] == 8'h1F)
    else $error("depth fallback wrong");

  // Scenarios worth seeing
  c_status_read: cover property (
    i_cfg_req.rd && hit(i_cfg_req.addr, PORT_STATUS_OFFSET));
  c_command_write: cover property (
    i_cfg_req.wr && hit(i_cfg_req.addr, PORT_COMMAND_OFFSET) && i_cfg_req.be == 4'hF);
  c_depth_one: cover property (depth == 8'h00);
  c_port_enabled: cover property (o_port_en && o_sideband_en);
  c_read_write_same: cover property (
    i_cfg_req.rd && i_cfg_req.wr && hit(i_cfg_req.addr, PORT_COMMAND_OFFSET));

endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the graphics port capability registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gfx_cap_pkg::*;
  logic i_clk;
  logic i_rst;
  cfg_req_t req;
  logic [2:0] depth_sel;
  cfg_rsp_t rsp;
  logic sb_en;
  logic port_en;
  logic [1:0] rate_sel;
  logic [31:0] exp_q[$];
  logic [31:0] cmd_model;
  logic [15:0] lfsr;
  int fail_count;
  int checks_done;
  int k;

  gfx_cap_regs u_gfx_cap_regs (.i_clk(i_clk), .i_rst(i_rst), .i_cfg_req(req),
    .i_depth_sel(depth_sel), .o_cfg_rsp(rsp), .o_sideband_en(sb_en), .o_port_en(port_en),
    .o_rate_sel(rate_sel));

  // 50 ns bridge clock
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Reported depth code for a selection; unused codes fall back to 32
  function automatic logic [7:0] depth_exp(input int s);
    return (s < 6) ? 8'((32 >> s) - 1) : 8'h1F;
  endfunction

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t rdata %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_ctrl(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t controls %h expected %h", $time, got, exp);
    end
  endtask

  // One access per edge; its expected answer goes on the queue
  task automatic access(input logic rd, input logic wr, input logic [7:0] addr,
    input logic [3:0] be, input logic [31:0] wdata, input logic [31:0] exp);
    @(posedge i_clk);
    req <= {rd, wr, addr, be, wdata};
    exp_q.push_back(exp);
  endtask

  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge i_clk);
      req <= '0;
    end
  endtask

  // Byte-gated command write, mirrored in the model
  task automatic cmd_write(input logic [3:0] be, input logic [31:0] wdata);
    int i;
    access(1'b0, 1'b1, PORT_COMMAND_OFFSET, be, wdata, 32'h0000_0000);
    for (i = 0; i < 4; i++)
      if (be[i])
        cmd_model[8*i +: 8] = wdata[8*i +: 8];
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Answer watcher, away from the launching edge
  always @(negedge i_clk)
  begin
    if (rsp.ack === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        fail_count++;
        $display("MISMATCH %0t unexpected answer", $time);
      end
      else
        check_word(rsp.rdata, exp_q.pop_front());
    end
  end

  initial
  begin
    i_rst = 1'b1;
    req = '0;
    depth_sel = 3'h0;
    cmd_model = 32'h0000_0000;
    lfsr = 16'h43DD;
    fail_count = 0;
    checks_done = 0;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    // Reset values back to back; low address bits ignored
    access(1'b1, 1'b0, CAP_ID_OFFSET, 4'h0, 32'h0000_0000, 32'h0010_0002);
    access(1'b1, 1'b0, 8'hA6, 4'h0, 32'h0000_0000, 32'h1F00_0203);
    access(1'b1, 1'b0, 8'hA8, 4'h0, 32'h0000_0000, 32'h0000_0000);
    access(1'b1, 1'b0, 8'hAC, 4'h0, 32'h0000_0000, 32'h0000_0000);
    // Writes to fixed registers leave them untouched
    access(1'b0, 1'b1, PORT_STATUS_OFFSET, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000);
    access(1'b0, 1'b1, CAP_ID_OFFSET, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000);
    access(1'b1, 1'b0, CAP_ID_OFFSET, 4'h0, 32'h0000_0000,
      {8'h00, 4'h1, 4'h0, 8'h00, 8'h02});
    access(1'b1, 1'b0, PORT_STATUS_OFFSET, 4'h0, 32'h0000_0000,
      32'h1F00_0203);
    // Every depth selection, including the unused codes
    for (k = 0; k < 8; k++)
    begin
      idle(1);
      depth_sel <= k[2:0];
      idle(3);
      access(1'b1, 1'b0, PORT_STATUS_OFFSET, 4'h0, 32'h0000_0000,
        {depth_exp(k), 24'h00_0203});
    end
    // Random byte-gated command writes, read back and seen at the controls
    for (k = 0; k < 6; k++)
    begin
      lfsr = lfsr_next(lfsr);
      cmd_write(lfsr[3:0] | ((k == 0) ? 4'hF : 4'h0), {lfsr, lfsr_next(lfsr)});
      access(1'b1, 1'b0, PORT_COMMAND_OFFSET, 4'h0, 32'h0000_0000, cmd_model);
      idle(2);
      @(negedge i_clk);
      check_ctrl({sb_en, port_en, rate_sel}, {cmd_model[9:8], cmd_model[1:0]});
    end
    // Read and write together return the old value
    access(1'b1, 1'b1, PORT_COMMAND_OFFSET, 4'hF, ~cmd_model, cmd_model);
    cmd_model = ~cmd_model;
    access(1'b1, 1'b0, PORT_COMMAND_OFFSET, 4'h0, 32'h0000_0000, cmd_model);
    // Reset in mid-run clears the command register
    idle(3);
    i_rst <= 1'b1;
    idle(2);
    i_rst <= 1'b0;
    cmd_model = 32'h0000_0000;
    access(1'b1, 1'b0, PORT_COMMAND_OFFSET, 4'h0, 32'h0000_0000, 32'h0000_0000);
    access(1'b1, 1'b0, PORT_STATUS_OFFSET, 4'h0, 32'h0000_0000, 32'h1F00_0203);
    idle(3);
    @(negedge i_clk);
    check_ctrl({sb_en, port_en, rate_sel}, 4'h0);
    for (k = 0; k < 20 && exp_q.size() != 0; k++)
      @(posedge i_clk);
    if (exp_q.size() != 0)
    begin
      fail_count++;
      $display("MISMATCH %0t answers missing", $time);
    end
    finish_test();
  end
endmodule
`default_nettype wire
